// *** src/usart_rx_defines.svh ***
// register map, field positions and reset values of the receiver
// assumes a 32-bit classic wishbone bus, byte address = 4 * index
`ifndef USART_RX_DEFINES_SVH
`define USART_RX_DEFINES_SVH

// ****************************************
// register indices
// ****************************************
`define RSC_IDX      6'h13
`define RXD_IDX      6'h14
`define TSC_IDX      6'h15
`define TXB_IDX      6'h16
`define BDV_IDX      6'h17
`define BANK1_OFS    6'h20
`define PFR_IDX      6'h16
`define PER_IDX      6'h17

// ****************************************
// field positions
// ****************************************
`define PORT_EN_BIT  7
`define NINE_SEL_BIT 6
`define SINGLE_BIT   5
`define CONT_BIT     4
`define CSM_BIT      7
`define TX_NINE_BIT  6
`define TX_ENA_BIT   5
`define SYNC_BIT     4
`define TX_NINTH_BIT 0
`define RCV_IE_BIT   0

// ****************************************
// reset values and sizes
// ****************************************
`define PFR_RST      8'h02
`define PER_RST      8'h00
`define BDV_RST      8'h03
`define FIFO_DEPTH   2'h2

`endif

// *** src/usart_rx_pkg.sv ***
// types shared by the receiver and its bus
// assumes the defines header supplies the numbers
package usart_rx_pkg;

  typedef struct packed
  {
    logic        framing_error;
    logic        ninth;
    logic [7:0]  data;
  } rx_entry_s;

  typedef struct packed
  {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef enum logic [0:0]
  {
    rx_idle  = 1'b0,
    rx_shift = 1'b1
  } rx_state_e;

endpackage

// *** src/baud_tick_gen.sv ***
// baud divider: one-cycle tick every divisor+1 clocks
// assumes run low holds it at the start of a period
`timescale 1ns/1ns
module baud_tick_gen
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [7:0] divisor,
  output logic            tick
);
  logic [7:0] count;

  always_ff @(posedge clk_sys)
  begin
    if (reset || !run)
    begin
      count <= 8'h00;
      tick  <= 1'b0;
    end
    else if (count == divisor)
    begin
      count <= 8'h00;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 8'h01;
      tick  <= 1'b0;
    end
  end
endmodule

// *** src/usart_sync_master_receive.sv ***
// synchronous master receiver with two-entry fifo and registers
// assumes a classic wishbone master and a slave peer on the pins
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ns
`include "usart_rx_defines.svh"
module usart_sync_master_receive
(
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire usart_rx_pkg::wb_req_s wb_req,
  output logic                       wb_ack,
  output logic [31:0]                wb_dat_rd,
  output logic                       ck_o,
  output logic                       ck_oe,
  input  wire logic                  dt_i,
  output logic                       dt_o,
  output logic                       dt_oe,
  output logic                       rx_irq
);
  import usart_rx_pkg::*;

  logic            serial_port_enable;
  logic            nine_bit_receive_select;
  logic            single_receive_enable;
  logic            continuous_receive_enable;
  logic            overrun_error_flag;
  logic            clock_source_master;
  logic            sync_mode;
  logic [2:0]      tx_misc;
  logic [7:0]      peripheral_enable_reg;
  logic [7:0]      baud_divisor;
  logic            req_hit;
  logic            wr_en;
  logic            rd_en;
  logic [5:0]      idx;
  logic [7:0]      rd_byte;
  logic            dt_meta;
  logic            dt_s;
  logic            rx_active;
  logic            baud_tick;
  rx_state_e       state;
  logic [3:0]      bit_cnt;
  logic [8:0]      receive_shift_register;
  logic [8:0]      next_shift;
  logic            bit_fall;
  logic            last_bit;
  logic            word_done;
  logic            push;
  logic            pop;
  logic            overrun_evt;
  rx_entry_s       receive_data_fifo [2];
  rx_entry_s       head;
  logic            wr_ptr;
  logic            rd_ptr;
  logic [1:0]      fifo_count;
  logic            receive_flag;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // ****************************************
  // wishbone slave
  // ****************************************
  assign req_hit = wb_req.cyc & wb_req.stb & ~wb_ack;
  assign wr_en   = req_hit & wb_req.we & wb_req.sel[0];
  assign rd_en   = req_hit & ~wb_req.we;
  assign idx     = wb_req.adr[7:2];

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      wb_ack <= 1'b0;
    else
      wb_ack <= req_hit;
  end

  always_comb
  begin
    rd_byte = 8'h00;
    unique case (idx)
      `RSC_IDX:
        rd_byte = {serial_port_enable, nine_bit_receive_select,
                   single_receive_enable, continuous_receive_enable,
                   1'b0, head.framing_error,
                   overrun_error_flag, head.ninth};
      `RXD_IDX:
        rd_byte = head.data;
      `TSC_IDX:
        rd_byte = {clock_source_master, tx_misc[2:1], sync_mode,
                   3'h1, tx_misc[0]};
      `BDV_IDX:
        rd_byte = baud_divisor;
      `BANK1_OFS + `PFR_IDX:
        rd_byte = {7'h01, receive_flag};
      `BANK1_OFS + `PER_IDX:
        rd_byte = peripheral_enable_reg;
      default:
        rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      wb_dat_rd <= 32'h0000_0000;
    else if (rd_en)
      wb_dat_rd <= {24'h00_0000, rd_byte};
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      serial_port_enable        <= 1'b0;
      nine_bit_receive_select   <= 1'b0;
      continuous_receive_enable <= 1'b0;
    end
    else if (wr_en && idx == `RSC_IDX)
    begin
      serial_port_enable        <= wb_req.dat[`PORT_EN_BIT];
      nine_bit_receive_select   <= wb_req.dat[`NINE_SEL_BIT];
      continuous_receive_enable <= wb_req.dat[`CONT_BIT];
    end
  end

  // a software write wins over the end-of-word clear
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      single_receive_enable <= 1'b0;
    else if (wr_en && idx == `RSC_IDX)
      single_receive_enable <= wb_req.dat[`SINGLE_BIT];
    else if (word_done)
      single_receive_enable <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      overrun_error_flag <= 1'b0;
    else if (overrun_evt)
      overrun_error_flag <= 1'b1;
    else if (wr_en && idx == `RSC_IDX && !wb_req.dat[`CONT_BIT])
      overrun_error_flag <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      clock_source_master <= 1'b0;
      sync_mode           <= 1'b0;
      tx_misc             <= 3'h0;
    end
    else if (wr_en && idx == `TSC_IDX)
    begin
      clock_source_master <= wb_req.dat[`CSM_BIT];
      sync_mode           <= wb_req.dat[`SYNC_BIT];
      tx_misc <= {wb_req.dat[`TX_NINE_BIT], wb_req.dat[`TX_ENA_BIT],
                  wb_req.dat[`TX_NINTH_BIT]};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      baud_divisor <= `BDV_RST;
    else if (wr_en && idx == `BDV_IDX)
      baud_divisor <= wb_req.dat[7:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      peripheral_enable_reg <= `PER_RST;
    else if (wr_en && idx == `BANK1_OFS + `PER_IDX)
      peripheral_enable_reg <= wb_req.dat[7:0];
  end

  // ****************************************
  // pins and serial clock
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      dt_meta <= 1'b0;
      dt_s    <= 1'b0;
    end
    else
    begin
      dt_meta <= dt_i;
      dt_s    <= dt_meta;
    end
  end

  // single enable counts only as master; slave and async do not run
  assign rx_active = serial_port_enable & sync_mode & clock_source_master
                     & (continuous_receive_enable
                        | single_receive_enable);

  assign dt_o  = 1'b0;
  assign dt_oe = 1'b0;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ck_oe <= 1'b0;
    else
      ck_oe <= serial_port_enable & sync_mode
               & clock_source_master;
  end

  baud_tick_gen u_baud
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .run     (rx_active),
    .divisor (baud_divisor),
    .tick    (baud_tick)
  );

  assign bit_fall  = baud_tick & ck_o;
  assign last_bit  = bit_cnt == (nine_bit_receive_select ? 4'h8 : 4'h7);
  assign word_done = bit_fall & last_bit;

  // ****************************************
  // shift engine
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (reset || !rx_active)
    begin
      state   <= rx_idle;
      ck_o    <= 1'b0;
      bit_cnt <= 4'h0;
    end
    else if (baud_tick)
    begin
      state <= rx_shift;
      ck_o  <= ~ck_o;
      if (ck_o)
        bit_cnt <= last_bit ? 4'h0 : bit_cnt + 4'h1;
    end
  end

  always_comb
  begin
    next_shift          = receive_shift_register;
    next_shift[bit_cnt] = dt_s;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset || !rx_active)
      receive_shift_register <= 9'h000;
    else if (bit_fall)
      receive_shift_register <= next_shift;
  end

  // ****************************************
  // receive fifo
  // ****************************************
  assign push = word_done && fifo_count != `FIFO_DEPTH
                && !overrun_error_flag;
  assign overrun_evt = word_done && fifo_count == `FIFO_DEPTH;
  assign pop  = rd_en && idx == `RXD_IDX && fifo_count != 2'h0;
  assign head = receive_data_fifo[rd_ptr];
  assign receive_flag = fifo_count != 2'h0;
  assign rx_irq = receive_flag
                  & peripheral_enable_reg[`RCV_IE_BIT];

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      receive_data_fifo[0] <= '0;
      receive_data_fifo[1] <= '0;
    end
    else if (push)
    begin
      receive_data_fifo[wr_ptr].data  <= next_shift[7:0];
      receive_data_fifo[wr_ptr].ninth <=
        nine_bit_receive_select & next_shift[8];
      receive_data_fifo[wr_ptr].framing_error <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wr_ptr     <= 1'b0;
      rd_ptr     <= 1'b0;
      fifo_count <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        fifo_count <= fifo_count + 2'h1;
      else if (pop && !push)
        fifo_count <= fifo_count - 2'h1;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_bit3_zero: assert property (
    rd_en && idx == `RSC_IDX |=> wb_dat_rd[3] == 1'b0)
    else $error("reserved bit 3 read as one");

  a_ninth_shown: assert property (
    rd_en && idx == `RSC_IDX |=> wb_dat_rd[0] == $past(head.ninth))
    else $error("ninth bit not shown in status");

  a_push_flag: assert property (
    push |=> receive_flag && fifo_count != 2'h0)
    else $error("push did not raise receive flag");

  a_flag_clears: assert property (
    pop && fifo_count == 2'h1 && !push |=> !receive_flag)
    else $error("receive flag stayed after last read");

  a_irq_raised: assert property (
    push && peripheral_enable_reg[`RCV_IE_BIT] && !wr_en |=> rx_irq)
    else $error("enabled interrupt not raised");

  a_overrun_set: assert property (
    word_done && fifo_count == 2'h2 |=> overrun_error_flag
    && fifo_count == $past(fifo_count) - {1'b0, $past(pop)})
    else $error("overrun not flagged or word kept");

  a_overrun_block: assert property (
    overrun_error_flag && word_done |=> fifo_count <= $past(fifo_count))
    else $error("transfer while overrun set");

  a_single_end: assert property (
    word_done && !(wr_en && idx == `RSC_IDX) |=> !single_receive_enable
    ##1 (continuous_receive_enable || state == rx_idle))
    else $error("single reception did not stop");

  a_sample_fall: assert property (
    bit_fall |=> !ck_o && receive_shift_register[$past(bit_cnt)]
    == $past(dt_s))
    else $error("bit not taken on falling clock");

  a_disable_idle: assert property (
    !serial_port_enable |=> state == rx_idle && !ck_o)
    else $error("receive logic not reset on disable");

  a_clock_starts: assert property (
    $rose(rx_active) && baud_divisor < 8'h08
    |-> ##[1:12] ck_o)
    else $error("serial clock did not start");

  c_push: cover property (push);
  c_full: cover property (fifo_count == 2'h2);
  c_overrun: cover property (overrun_evt);
  c_single: cover property (word_done && !continuous_receive_enable);
endmodule

// *** tb/sync_peer.sv ***
// slave peer on the serial clock and data pins
// assumes the master idles the clock low and samples on its fall
`timescale 1ns/1ns
module sync_peer
(
  input  wire logic        clk_sys,
  input  wire logic        ck,
  input  wire logic        restart,
  input  wire logic        nine,
  input  wire logic [26:0] frames,
  output logic             dt,
  output logic [3:0]       words
);
  logic [3:0] bit_idx;
  logic       shown = 1'b0;
  logic [1:0] since_fall = 2'h0;

  // next bit shown just after the clock rises, lsb first
  always @(posedge ck)
    shown <= frames[9 * (words % 3) + bit_idx];

  // count bits and words at each falling clock
  always @(negedge ck or posedge restart)
  begin
    if (restart)
    begin
      bit_idx <= 4'h0;
      words   <= 4'h0;
    end
    else if (bit_idx == (nine ? 4'h8 : 4'h7))
    begin
      bit_idx <= 4'h0;
      words   <= words + 4'h1;
    end
    else
      bit_idx <= bit_idx + 4'h1;
  end

  // three cycles after a fall the hold time is over; line goes stale
  always @(posedge clk_sys)
  begin
    if (ck)
      since_fall <= 2'h0;
    else if (since_fall != 2'h3)
      since_fall <= since_fall + 2'h1;
  end

  assign dt = (!ck && since_fall == 2'h3) ? ~shown : shown;
endmodule

// *** tb/usart_sync_master_receive_tb_top.sv ***
// register-level tests of the receiver against a slave peer
// assumes a registered wishbone ack and a 100 MHz clk_sys
`timescale 1ns/1ns
module usart_sync_master_receive_tb_top;
  import usart_rx_pkg::*;
  logic        clk_sys;
  logic        reset;
  wb_req_s     wb_req;
  logic        wb_ack;
  logic [31:0] wb_dat_rd;
  logic        ck_o;
  logic        ck_oe;
  logic        dt;
  logic        dt_out;
  logic        dt_oe;
  logic        rx_irq;
  logic        restart;
  logic        nine;
  logic [26:0] frames;
  logic [3:0]  words;
  logic [7:0]  rd;
  int          num_errors;
  int          n_checks;

  usart_sync_master_receive u_usart_sync_master_receive
  (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .wb_req    (wb_req),
    .wb_ack    (wb_ack),
    .wb_dat_rd (wb_dat_rd),
    .ck_o      (ck_o),
    .ck_oe     (ck_oe),
    .dt_i      (dt),
    .dt_o      (dt_out),
    .dt_oe     (dt_oe),
    .rx_irq    (rx_irq)
  );

  sync_peer u_sync_peer
  (
    .clk_sys (clk_sys),
    .ck      (ck_o),
    .restart (restart),
    .nine    (nine),
    .frames  (frames),
    .dt      (dt),
    .words   (words)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [7:0] wd);
    int n;
    n = 0;
    wb_req <= '{1'b1, 1'b1, we, adr, 4'h1, {24'h0, wd}};
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 100);
    if (wb_ack !== 1'b1)
    begin
      num_errors++;
      complete_run();
    end
    rd = wb_dat_rd[7:0];
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
    bus(1'b1, adr, wd);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, 8'h00);
    chk(rd, exp);
  endtask

  task automatic arm(input logic nine_v, input logic [26:0] fr);
    nine    <= nine_v;
    frames  <= fr;
    restart <= 1'b1;
    @(posedge clk_sys);
    restart <= 1'b0;
  endtask

  task automatic wait_words(input logic [3:0] n);
    int k;
    k = 0;
    while (words !== n && k < 2000)
    begin
      @(posedge clk_sys);
      k++;
    end
    repeat (2) @(posedge clk_sys);
    chk({4'h0, words}, {4'h0, n});
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****************************************
  // clock, watchdog and tests
  // ****************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    #200000;
    num_errors++;
    complete_run();
  end

  initial
  begin
    reset      = 1'b1;
    wb_req     = '0;
    restart    = 1'b0;
    nine       = 1'b0;
    frames     = '0;
    num_errors = 0;
    n_checks   = 0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rdc(8'h4c, 8'h00);
    rdc(8'h54, 8'h02);
    rdc(8'hd8, 8'h02);
    rdc(8'hdc, 8'h00);
    rdc(8'h5c, 8'h03);
    wr(8'h60, 8'hff);
    rdc(8'h60, 8'h00);
    wr(8'h4c, 8'h08);
    rdc(8'h4c, 8'h00);
    chk({7'h0, ck_oe}, 8'h00);
    // slave mode: single enable must not start a word
    wr(8'h54, 8'h10);
    wr(8'h4c, 8'ha0);
    repeat (40) @(posedge clk_sys);
    chk({7'h0, ck_o}, 8'h00);
    wr(8'h4c, 8'h80);
    wr(8'h5c, 8'h03);
    wr(8'h54, 8'h90);
    chk({7'h0, ck_oe}, 8'h01);
    chk({6'h0, dt_oe, dt_out}, 8'h00);
    wr(8'hdc, 8'h01);
    arm(1'b0, {18'h0, 9'h0a5});
    wr(8'h4c, 8'ha0);
    wait_words(4'h1);
    chk({7'h0, rx_irq}, 8'h01);
    wr(8'hd8, 8'hff);
    rdc(8'hd8, 8'h03);
    rdc(8'h4c, 8'h80);
    rdc(8'h50, 8'ha5);
    rdc(8'hd8, 8'h02);
    chk({7'h0, rx_irq}, 8'h00);
    chk({7'h0, ck_o}, 8'h00);
    // nine bits with the interrupt masked
    wr(8'hdc, 8'h00);
    arm(1'b1, {18'h0, 9'h13c});
    wr(8'h4c, 8'he0);
    wait_words(4'h1);
    chk({7'h0, rx_irq}, 8'h00);
    rdc(8'h4c, 8'hc1);
    rdc(8'h50, 8'h3c);
    // continuous run into overrun
    arm(1'b0, {9'h033, 9'h022, 9'h011});
    wr(8'h4c, 8'h90);
    wait_words(4'h3);
    rdc(8'h4c, 8'h92);
    rdc(8'h50, 8'h11);
    wait_words(4'h4);
    wr(8'h4c, 8'h80);
    rdc(8'h4c, 8'h80);
    rdc(8'h50, 8'h22);
    rdc(8'hd8, 8'h02);
    // port disable drops the clock enable, then a clean word
    wr(8'h4c, 8'h00);
    chk({7'h0, ck_oe}, 8'h00);
    wr(8'h4c, 8'h80);
    arm(1'b0, {18'h0, 9'h05a});
    wr(8'h4c, 8'ha0);
    wait_words(4'h1);
    rdc(8'h50, 8'h5a);
    complete_run();
  end
endmodule
